// ---- dv/acquisition_event_generator_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module acquisition_event_generator_tb_top import acq_event_pkg::*;;
  logic                  clk, reset, extTrigger, softTrigger, planarMode;
  logic                  outStrobe, serviceOn, parStrobeOut, oddField;
  logic                  hostIrq, prevOdd, trigActiveHigh;
  logic [DEB_W-1:0]      trigMinWidth;
  logic [7:0]            outValue, inValue, parOut;
  logic [NUM_EVENTS-1:0] eventEnable, eventAck, eventPending, pv;
  acq_in_t               acqIn;
  par_in_t               parIn;
  par_cfg_t              parCfg;
  int                    mismatches, comparisons, fb;

  acquisition_event_generator DUT (
    .clk(clk), .reset(reset), .extTrigger(extTrigger),
    .trigActiveHigh(trigActiveHigh), .trigMinWidth(trigMinWidth),
    .softTrigger(softTrigger), .acqIn(acqIn), .planarMode(planarMode),
    .parIn(parIn), .parCfg(parCfg), .outValue(outValue),
    .outStrobe(outStrobe), .eventEnable(eventEnable), .eventAck(eventAck),
    .eventPending(eventPending), .inValue(inValue), .parOut(parOut),
    .parStrobeOut(parStrobeOut), .oddField(oddField), .hostIrq(hostIrq)
  );
  host_irq_model host (
    .clk(clk), .reset(reset), .serviceOn(serviceOn), .hostIrq(hostIrq),
    .eventPending(eventPending), .eventAck(eventAck)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // host acks everything, then goes quiet again
  task automatic clearAll();
    eventEnable = '1;
    serviceOn = 1'b1;
    cyc(4);
    serviceOn = 1'b0;
    cyc(1);
  endtask
  task automatic expectOnly(input string nm, input logic [31:0] e);
    cyc(3);
    chk(nm, e, eventPending);
    clearAll();
  endtask
  task automatic field(input int k);
    acqIn.vsync = 1'b1;
    cyc(1);
    acqIn.vsync = 1'b0;
    cyc(3);
    pv = eventPending;
    fb += pv[EV_FRAME_BEG];
    chk("fieldBeg", 1, pv[EV_FIELD_BEG]);
    chk("oddXorEven", 1, pv[EV_ODD_BEG] ^ pv[EV_EVEN_BEG]);
    if (k > 0)
      chk("parityFlip", !prevOdd, pv[EV_ODD_BEG]);
    chk("oddField", pv[EV_ODD_BEG], oddField);
    prevOdd = pv[EV_ODD_BEG];
    clearAll();
    repeat (6) begin
      acqIn.hsync = 1'b1;
      cyc(1);
      acqIn.hsync = 1'b0;
      cyc(1);
    end
  endtask
  task automatic close_out();
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    {extTrigger, softTrigger, planarMode, outStrobe, serviceOn} = '0;
    {acqIn, parIn, parCfg, outValue, eventEnable} = '0;
    trigMinWidth = 16'h0008;
    trigActiveHigh = 1'b1;
    cyc(5);
    reset = 1'b0;
    cyc(1);
    chk("pendReset", 0, eventPending);
    chk("irqReset", 0, hostIrq);
    softTrigger = 1'b1;
    cyc(1);
    softTrigger = 1'b0;
    cyc(10);
    chk("softTrig", 0, eventPending);
    extTrigger = 1'b1;
    cyc(3);
    extTrigger = 1'b0;
    cyc(15);
    chk("shortTrig", 0, eventPending);
    extTrigger = 1'b1;
    cyc(20);
    extTrigger = 1'b0;
    chk("longTrig", 1, eventPending);
    chk("maskedIrq", 0, hostIrq);
    eventEnable = 24'h000001;
    cyc(1);
    chk("irqUp", 1, hostIrq);
    clearAll();
    chk("ackClear", 0, eventPending);
    acqIn.vsync = 1'b1;
    cyc(1);
    acqIn.vsync = 1'b0;
    expectOnly("progVsync", 32'h2);
    acqIn.interlaced = 1'b1;
    for (int k = 0; k < 4; k++) begin
      field(k);
    end
    chk("frameBegPairs", 2, fb);
    acqIn.frameStored = 1'b1;
    cyc(1);
    acqIn.frameStored = 1'b0;
    cyc(3);
    pv = eventPending;
    chk("fieldSt", 1, pv[EV_FIELD_ST]);
    chk("oddEvenSt", 1, pv[EV_ODD_ST] ^ pv[EV_EVEN_ST]);
    clearAll();
    acqIn.interlaced = 1'b0;
    acqIn.frameStored = 1'b1;
    cyc(1);
    acqIn.frameStored = 1'b0;
    expectOnly("frameSt", 32'h20);
    planarMode = 1'b1;
    for (int i = 0; i < 3; i++) begin
      acqIn.xferDone[i] = 1'b1;
      cyc(1);
      acqIn.xferDone[i] = 1'b0;
      expectOnly("xferDone", 32'h200 << i);
    end
    parCfg.pinRiseSel = 8'h55;
    for (int i = 0; i < 8; i++) begin
      parIn.pins[i] = 1'b1;
      expectOnly("pinRise", i % 2 ? 0 : 32'h1000 << i);
      parIn.pins[i] = 1'b0;
      expectOnly("pinFall", i % 2 ? 32'h1000 << i : 0);
    end
    parIn.ioInt = 1'b1;
    expectOnly("ioIntRise", 0);
    parIn.ioInt = 1'b0;
    expectOnly("ioIntFall", 32'h100000);
    parIn.pins = 8'hA5;
    cyc(1);
    chk("rawIn", 8'hA5, inValue);
    // strobe active low here, idle high
    parCfg.latchMode = 1'b1;
    parIn.strobeIn = 1'b1;
    parIn.pins = 8'h5A;
    cyc(2);
    parIn.strobeIn = 1'b0;
    cyc(2);
    parIn.strobeIn = 1'b1;
    cyc(1);
    parIn.pins = 8'hC3;
    cyc(2);
    chk("latchedIn", 8'h5A, inValue);
    outValue = 8'h96;
    outStrobe = 1'b1;
    cyc(1);
    chk("parOut", 8'h96, parOut);
    chk("strobeOut", 1, parStrobeOut);
    close_out();
  end
endmodule // acquisition_event_generator_tb_top
`default_nettype wire

// ---- dv/host_irq_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// host side: while servicing, acks every pending flag behind a raised line
module host_irq_model
  import acq_event_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  serviceOn,
  input  wire logic                  hostIrq,
  input  wire logic [NUM_EVENTS-1:0] eventPending,
  output logic      [NUM_EVENTS-1:0] eventAck
);
  always_ff @(posedge clk) begin
    if (reset || !serviceOn || !hostIrq) begin
      eventAck <= '0;
    end else begin
      eventAck <= eventPending;
    end
  end
endmodule // host_irq_model
`default_nettype wire

// ---- rtl/acquisition_event_generator.sv ----
`timescale 1ns/1ps
`default_nettype none
module acquisition_event_generator
  import acq_event_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  extTrigger,
  input  wire logic                  trigActiveHigh,
  input  wire logic [DEB_W-1:0]      trigMinWidth,
  input  wire logic                  softTrigger,
  input  wire acq_in_t               acqIn,
  input  wire logic                  planarMode,
  input  wire par_in_t               parIn,
  input  wire par_cfg_t              parCfg,
  input  wire logic [7:0]            outValue,
  input  wire logic                  outStrobe,
  input  wire logic [NUM_EVENTS-1:0] eventEnable,
  input  wire logic [NUM_EVENTS-1:0] eventAck,
  output logic [NUM_EVENTS-1:0]      eventPending,
  output logic [7:0]                 inValue,
  output logic [7:0]                 parOut,
  output logic                       parStrobeOut,
  output logic                       oddField,
  output logic                       hostIrq
);
  typedef struct packed {
    logic [DEB_W-1:0]      debCnt;
    logic                  trigStable;
    logic                  vsPrev;
    logic [PARITY_W-1:0]   hsSinceVs;
    logic [PARITY_W-1:0]   lastHsGap;
    logic                  odd;
    logic                  frameHalf;
    logic                  fsPrev;
    logic [2:0]            xdPrev;
    logic                  strobePrev;
    logic [7:0]            latched;
    logic [7:0]            outR;
    logic                  outStrobeR;
    logic [NUM_EVENTS-1:0] pend;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [7:0]            pinPulse;
  logic                  ioIntPulse;
  logic                  strobeAct;
  logic                  vsRise;
  logic                  fsRise;
  logic [2:0]            xdRise;
  logic [NUM_EVENTS-1:0] evSet;
  logic                  trigRaw;

  // per-pin edge events with independent direction
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      edge_event u_pin (
        .clk    (clk),
        .reset  (reset),
        .sigIn  (parIn.pins[gi]),
        .riseSel(parCfg.pinRiseSel[gi]),
        .pulse  (pinPulse[gi])
      );
    end
  endgenerate

  edge_event u_ioint (
    .clk    (clk),
    .reset  (reset),
    .sigIn  (parIn.ioInt),
    .riseSel(parCfg.ioIntRise),
    .pulse  (ioIntPulse)
  );

  assign trigRaw   = trigActiveHigh ? extTrigger : ~extTrigger;
  assign vsRise    = acqIn.vsync & ~st_r.vsPrev;
  assign fsRise    = acqIn.frameStored & ~st_r.fsPrev;
  assign xdRise    = acqIn.xferDone & ~st_r.xdPrev;
  assign strobeAct = parCfg.strobeHigh ?
                     (parIn.strobeIn & ~st_r.strobePrev) :
                     (~parIn.strobeIn & st_r.strobePrev);

  always_comb begin
    logic nextOdd;
    logic trigEdge;
    nextOdd  = 1'b0;
    trigEdge = 1'b0;
    st_nxt = st_r;
    evSet  = '0;
    st_nxt.vsPrev     = acqIn.vsync;
    st_nxt.fsPrev     = acqIn.frameStored;
    st_nxt.xdPrev     = acqIn.xferDone;
    st_nxt.strobePrev = parIn.strobeIn;

    // debounce: level must stay active for trigMinWidth+1 cycles
    if (trigRaw != st_r.trigStable) begin
      if (st_r.debCnt >= trigMinWidth) begin
        st_nxt.trigStable = trigRaw;
        st_nxt.debCnt     = '0;
        trigEdge          = trigRaw;
      end else begin
        st_nxt.debCnt = st_r.debCnt + 1'b1;
      end
    end else begin
      st_nxt.debCnt = '0;
    end
    // software trigger input is ignored here on purpose
    evSet[EV_TRIG] = trigEdge;

    // field parity: hsync count since vsync; parity flips unless the gap is shorter than the last
    if (acqIn.hsync && !st_r.vsPrev) begin
      if (st_r.hsSinceVs != '1) begin
        st_nxt.hsSinceVs = st_r.hsSinceVs + 1'b1;
      end
    end
    nextOdd = 1'b1;
    if (vsRise) begin
      st_nxt.hsSinceVs = '0;
      st_nxt.lastHsGap = st_r.hsSinceVs;
      // a field at least as long as the previous one flips the parity
      nextOdd = acqIn.interlaced ?
                (st_r.hsSinceVs >= st_r.lastHsGap ? ~st_r.odd : st_r.odd)
                : 1'b1;
      st_nxt.odd = nextOdd;
      if (acqIn.interlaced) begin
        st_nxt.frameHalf = ~st_r.frameHalf;
      end else begin
        st_nxt.frameHalf = 1'b0;
      end
      evSet[EV_FRAME_BEG] = !acqIn.interlaced || nextOdd;
      evSet[EV_FIELD_BEG] = acqIn.interlaced;
      evSet[EV_ODD_BEG]   = acqIn.interlaced && nextOdd;
      evSet[EV_EVEN_BEG]  = acqIn.interlaced && !nextOdd;
    end

    if (fsRise) begin
      evSet[EV_FRAME_ST] = !acqIn.interlaced || !st_r.odd;
      evSet[EV_FIELD_ST] = acqIn.interlaced;
      evSet[EV_ODD_ST]   = acqIn.interlaced && st_r.odd;
      evSet[EV_EVEN_ST]  = acqIn.interlaced && !st_r.odd;
    end

    // one done per frame or field as presented by the transfer engine
    evSet[EV_BLUE_DONE]  = xdRise[0];
    evSet[EV_GREEN_DONE] = xdRise[1];
    evSet[EV_RED_DONE]   = xdRise[2];
    evSet[EV_PIN0 +: 8]  = pinPulse;
    evSet[EV_IOINT]      = ioIntPulse;

    if (parCfg.latchMode && strobeAct) begin
      st_nxt.latched = parIn.pins;
    end
    st_nxt.outR       = outValue;
    st_nxt.outStrobeR = outStrobe;

    // set wins over acknowledge
    st_nxt.pend = (st_r.pend & ~eventAck) | evSet;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r          <= '0;
      st_r.odd      <= 1'b1;
      st_r.pend     <= PEND_RESET;
      st_r.latched  <= PORT_RESET;
      st_r.outR     <= PORT_RESET;
      st_r.debCnt   <= DEB_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign eventPending = st_r.pend;
  assign inValue      = parCfg.latchMode ? st_r.latched : parIn.pins;
  assign parOut       = st_r.outR;
  assign parStrobeOut = st_r.outStrobeR;
  assign oddField     = st_r.odd;
  assign hostIrq      = |(st_r.pend & eventEnable);

  a_pend_sticky: assert property (@(posedge clk) disable iff (reset)
    ($past(st_r.pend[EV_TRIG]) && !$past(eventAck[EV_TRIG]))
      |-> st_r.pend[EV_TRIG])
    else $error("pending flag lost without acknowledge");

  a_irq_masked: assert property (@(posedge clk) disable iff (reset)
    ((st_r.pend & eventEnable) == '0) |-> !hostIrq)
    else $error("interrupt raised while all pending masked");

  a_trig_event: assert property (@(posedge clk) disable iff (reset)
    evSet[EV_TRIG] |=> st_r.pend[EV_TRIG])
    else $error("trigger event not recorded");

  a_field_pair: assert property (@(posedge clk) disable iff (reset)
    (vsRise && acqIn.interlaced) |=> st_r.pend[EV_FIELD_BEG])
    else $error("field begin missing on vertical sync");

  a_odd_even_excl: assert property (@(posedge clk) disable iff (reset)
    !(evSet[EV_ODD_BEG] && evSet[EV_EVEN_BEG]))
    else $error("odd and even begin together");

  a_prog_frame: assert property (@(posedge clk) disable iff (reset)
    (vsRise && !acqIn.interlaced) |=> st_r.pend[EV_FRAME_BEG])
    else $error("frame begin missing in progressive mode");

  a_pin_edge: assert property (@(posedge clk) disable iff (reset)
    (parCfg.pinRiseSel[0] && parIn.pins[0] && !$past(parIn.pins[0]))
      |=> st_r.pend[EV_PIN0])
    else $error("pin zero rising edge not recorded");

  a_latch_hold: assert property (@(posedge clk) disable iff (reset)
    (parCfg.latchMode && !strobeAct) |=> $stable(st_r.latched))
    else $error("latched input changed without strobe");

  a_soft_quiet: assert property (@(posedge clk) disable iff (reset)
    (softTrigger && (trigRaw == st_r.trigStable)) |-> !evSet[EV_TRIG])
    else $error("software trigger raised the trigger event");

  a_deb_reject: assert property (@(posedge clk) disable iff (reset)
    ((trigRaw != st_r.trigStable) && (st_r.debCnt < trigMinWidth))
      |-> !evSet[EV_TRIG])
    else $error("trigger accepted before minimum width");

  a_field_kind: assert property (@(posedge clk) disable iff (reset)
    (vsRise && acqIn.interlaced)
      |=> (st_r.pend[EV_ODD_BEG] || st_r.pend[EV_EVEN_BEG]))
    else $error("field begin without odd or even event");

  a_odd_flag: assert property (@(posedge clk) disable iff (reset)
    evSet[EV_ODD_BEG] |=> oddField)
    else $error("odd field begin but parity flag even");

  a_even_flag: assert property (@(posedge clk) disable iff (reset)
    evSet[EV_EVEN_BEG] |=> !oddField)
    else $error("even field begin but parity flag odd");

  a_store_frame: assert property (@(posedge clk) disable iff (reset)
    (fsRise && !acqIn.interlaced) |=> st_r.pend[EV_FRAME_ST])
    else $error("frame stored event missing");

  a_store_field: assert property (@(posedge clk) disable iff (reset)
    (fsRise && acqIn.interlaced) |=> st_r.pend[EV_FIELD_ST])
    else $error("field stored event missing");

  a_blue_done: assert property (@(posedge clk) disable iff (reset)
    xdRise[0] |=> st_r.pend[EV_BLUE_DONE])
    else $error("blue transfer done event missing");

  a_planar_red: assert property (@(posedge clk) disable iff (reset)
    (planarMode && xdRise[2]) |=> st_r.pend[EV_RED_DONE])
    else $error("red plane done event missing");

  a_ioint_edge: assert property (@(posedge clk) disable iff (reset)
    ioIntPulse |=> st_r.pend[EV_IOINT])
    else $error("interrupt input edge not recorded");

  a_out_reg: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> (parOut == $past(outValue)))
    else $error("output port not one cycle behind its value");

  // acknowledge with no new event clears the flag
  sequence s_ack_only;
    st_r.pend[EV_TRIG] && eventAck[EV_TRIG] && !evSet[EV_TRIG];
  endsequence

  sequence s_flag_clear;
    !st_r.pend[EV_TRIG];
  endsequence

  a_ack_clear: assert property (@(posedge clk) disable iff (reset)
    s_ack_only |=> s_flag_clear)
    else $error("acknowledged flag stayed pending");
endmodule // acquisition_event_generator
`default_nettype wire

// ---- rtl/edge_event.sv ----
`timescale 1ns/1ps
`default_nettype none
// edge detector against a registered previous value, pulse unregistered, selectable direction
module edge_event (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic sigIn,
  input  wire logic riseSel,
  output logic      pulse
);
  typedef struct packed {
    logic prev;
  } edge_state_t;
  edge_state_t st_r;
  edge_state_t st_nxt;

  always_comb begin
    st_nxt.prev = sigIn;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pulse = riseSel ? (sigIn & ~st_r.prev) : (~sigIn & st_r.prev);
endmodule // edge_event
`default_nettype wire

// ---- shared/acq_event_pkg.sv ----
`default_nettype none
package acq_event_pkg;
  localparam int NUM_EVENTS = 24;
  // pending flag positions
  localparam int EV_TRIG      = 0;
  localparam int EV_FRAME_BEG = 1;
  localparam int EV_FIELD_BEG = 2;
  localparam int EV_ODD_BEG   = 3;
  localparam int EV_EVEN_BEG  = 4;
  localparam int EV_FRAME_ST  = 5;
  localparam int EV_FIELD_ST  = 6;
  localparam int EV_ODD_ST    = 7;
  localparam int EV_EVEN_ST   = 8;
  localparam int EV_BLUE_DONE = 9;
  localparam int EV_GREEN_DONE = 10;
  localparam int EV_RED_DONE  = 11;
  localparam int EV_PIN0      = 12;
  localparam int EV_IOINT     = 20;
  localparam int EV_SPARE0    = 21;
  localparam int DEB_W        = 16;
  localparam int PARITY_W     = 16;
  localparam logic [NUM_EVENTS-1:0] PEND_RESET = 24'h000000;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [DEB_W-1:0] DEB_RESET = 16'h0000;

  typedef struct packed {
    logic [7:0] pins;
    logic       strobeIn;
    logic       ioInt;
  } par_in_t;

  typedef struct packed {
    logic [7:0] pinRiseSel;
    logic       latchMode;
    logic       strobeHigh;
    logic       ioIntRise;
  } par_cfg_t;

  typedef struct packed {
    logic vsync;
    logic hsync;
    logic interlaced;
    logic frameStored;
    logic [2:0] xferDone;
  } acq_in_t;
endpackage
`default_nettype wire
